// *** core/flag_map_store.v ***
`timescale 1ns/10ps
`default_nettype none
`include "status_responder_defines.vh"

module flag_map_store
#(
   parameter NFLAG = `FLAG_COUNT,
   parameter AW = 4
)
(
   input wire mclk_i,
   input wire rstn_i,
   input wire defaults_i,
   input wire wr_i,
   input wire [AW-1:0] wr_idx_i,
   input wire [15:0] wr_mask_i,
   output wire [16*NFLAG-1:0] masks_o
);

   // ==========================================================================
   // Default mapping table.
   // ==========================================================================

   // Returns the default bit assignment for one flag.
   function [15:0] def_mask;
      input integer idx;
      begin
         case (idx)
            `FL_SAMPLE_FLOW: def_mask = `DEF_SAMPLE_FLOW;
            `FL_BENCH_TEMP: def_mask = `DEF_BENCH_TEMP;
            `FL_SOURCE: def_mask = `DEF_SOURCE;
            `FL_BOX_TEMP: def_mask = `DEF_BOX_TEMP;
            `FL_WHEEL_TEMP: def_mask = `DEF_WHEEL_TEMP;
            `FL_SAMPLE_TEMP: def_mask = `DEF_SAMPLE_TEMP;
            `FL_SAMPLE_PRES: def_mask = `DEF_SAMPLE_PRES;
            `FL_INVALID_CONC: def_mask = `DEF_INVALID_CONC;
            `FL_INST_OFF: def_mask = `DEF_INST_OFF;
            `FL_MANUAL_CAL: def_mask = `DEF_MANUAL_CAL;
            `FL_ZERO_CAL: def_mask = `DEF_ZERO_CAL;
            `FL_SPAN_CAL: def_mask = `DEF_SPAN_CAL;
            default: def_mask = 16'h0000;
         endcase
      end
   endfunction

   // ==========================================================================
   // One mask register per flag.
   // ==========================================================================

   genvar g;
   generate
      for (g = 0; g < NFLAG; g = g + 1)
      begin : g_map
         localparam [15:0] DEF = def_mask(g);
         localparam [AW-1:0] IDX = g;
         reg [15:0] mask_r;
         // Reset and the restore strobe reload the default; a write replaces one entry.
         always @(posedge mclk_i or negedge rstn_i)
         begin
            if (!rstn_i)
               mask_r <= DEF;
            else if (defaults_i)
               mask_r <= DEF;
            else if (wr_i && (wr_idx_i == IDX))
               mask_r <= wr_mask_i;
         end
         assign masks_o[16*g +: 16] = mask_r;
      end
   endgenerate

endmodule
`default_nettype wire

// *** core/multidrop_status_responder.v ***
// Function
// - Two protocol variants, one device-wide setting.
// - Per-port enable; variant shared by both.
// - Command mode framing follows command encoding.
// - Checksum mode: STX, ETX, two-digit check.
// - Text mode: CR at start and end.
// - Fixed gas identifier, default 310.
// - Status word from assignable flags.
// - Default warning bit assignments.
// - Default operational bit assignments.
// - Two-bit unit field in status word.
// - Shared bit is OR of flags.
// - Assignments changeable and restorable to default.
// - Programmable instrument identifier, default 360.
// - Never initiate; answer only own identifier.
// - Seven data bits, two stop, even parity.
// - Reply within latency; host paces commands.
`timescale 1ns/10ps
`default_nettype none
`include "status_responder_defines.vh"

module multidrop_status_responder
#(
   parameter NFLAG = `FLAG_COUNT,
   parameter [15:0] GAS_ID = `GAS_ID_DEFAULT,
   parameter LATENCY_CYC = `REPLY_LATENCY_MS * 1000 * `CLK_MHZ
)
(
   input wire mclk_i,
   input wire rstn_i,
   input wire variant_i,
   input wire [1:0] port_en_i,
   input wire [1:0] resp_mode_i,
   input wire [15:0] inst_id_i,
   input wire inst_id_load_i,
   input wire [NFLAG-1:0] flags_i,
   input wire [1:0] unit_i,
   input wire map_defaults_i,
   input wire map_wr_i,
   input wire [3:0] map_idx_i,
   input wire [15:0] map_mask_i,
   input wire cmd_valid_i,
   input wire cmd_port_i,
   input wire [15:0] cmd_id_i,
   input wire cmd_enc_i,
   output wire cmd_ready_o,
   output reg char_valid_o,
   output reg [6:0] char_o,
   output reg char_parity_o,
   output reg char_port_o,
   input wire char_ready_i,
   output reg [15:0] status_o,
   output reg [15:0] inst_id_o,
   output wire [15:0] gas_id_o,
   output reg variant_o,
   output wire busy_o,
   output reg timeout_o
);

   // ==========================================================================
   // Synchronise the asynchronous flag inputs.
   // ==========================================================================

   reg [NFLAG-1:0] flags_meta_r;
   reg [NFLAG-1:0] flags_sync_r;

   // Two-stage synchroniser; only the second stage feeds logic.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         flags_meta_r <= {NFLAG{1'b0}};
         flags_sync_r <= {NFLAG{1'b0}};
      end
      else
      begin
         flags_meta_r <= flags_i;
         flags_sync_r <= flags_meta_r;
      end
   end

   // ==========================================================================
   // Flag to status bit mapping.
   // ==========================================================================

   wire [16*NFLAG-1:0] masks;

   flag_map_store #(.NFLAG(NFLAG), .AW(4)) u_map
   (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .defaults_i(map_defaults_i),
      .wr_i(map_wr_i),
      .wr_idx_i(map_idx_i),
      .wr_mask_i(map_mask_i),
      .masks_o(masks)
   );

   // Each active flag contributes its mask; overlapping masks OR together.
   wire [16*(NFLAG+1)-1:0] acc;
   assign acc[15:0] = 16'h0000;
   genvar g;
   generate
      for (g = 0; g < NFLAG; g = g + 1)
      begin : g_or
         assign acc[16*(g+1) +: 16] = acc[16*g +: 16] | (flags_sync_r[g] ? masks[16*g +: 16] : 16'h0000);
      end
   endgenerate

   wire [15:0] unit_field = {1'b0, unit_i, 13'h0000};

   // Status word is registered; the unit field is ORed into bits 13 and 14.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         status_o <= 16'h0000;
      else
         status_o <= acc[16*NFLAG +: 16] | unit_field;
   end

   // ==========================================================================
   // Identifiers and the device-wide variant.
   // ==========================================================================

   assign gas_id_o = GAS_ID;

   // Instrument identifier loads on request and restarts at its default.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         inst_id_o <= `INST_ID_DEFAULT;
      else if (inst_id_load_i)
         inst_id_o <= inst_id_i;
   end

   // Variant is captured only between replies so a frame never mixes variants.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         variant_o <= `VARIANT_ORIGINAL;
      else if (!busy_o)
         variant_o <= variant_i;
   end

   // ==========================================================================
   // Reply sequencer.
   // ==========================================================================

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_LEAD = 3'h1;
   localparam [2:0] ST_BODY = 3'h2;
   localparam [2:0] ST_TAIL = 3'h3;
   localparam [2:0] ST_BCC1 = 3'h4;
   localparam [2:0] ST_BCC2 = 3'h5;
   localparam [2:0] ST_CONV = 3'h6;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [1:0] mode_r;
   reg enc_r;
   reg [3:0] idx_r;
   reg [6:0] bcc_r;
   reg [2:0] ret_r;
   reg [31:0] lat_r;
   reg [3:0] nib;
   reg [6:0] char_new;
   reg char_load;
   wire [6:0] hex_ch;

   reply_char_rom u_rom
   (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .nibble_i(nib),
      .ascii_o(hex_ch)
   );

   // Accept only when idle, enabled on that port, and addressed to this unit.
   wire own_cmd = cmd_valid_i && port_en_i[cmd_port_i] && (cmd_id_i == inst_id_o);
   assign cmd_ready_o = (state_r == ST_IDLE);
   assign busy_o = (state_r != ST_IDLE);
   wire framed = (mode_r == `RMODE_BCC) || ((mode_r == `RMODE_CMD) && (enc_r == `CENC_FRAMED));
   // Framing of the command being accepted; the unused mode code behaves as command mode.
   wire framed_next = (resp_mode_i == `RMODE_BCC) || ((resp_mode_i != `RMODE_TEXT) && (cmd_enc_i == `CENC_FRAMED));

   // The converter is registered, so it is fed the digit that the next convert cycle will present.
   wire [3:0] dig_idx = (state_r == ST_BODY) ? idx_r + 4'h1 : idx_r;
   wire [6:0] bcc_fold = bcc_r ^ char_o;

   // Body: variant marker, gas id, instrument id, status word, each as hex digits.
   always @*
   begin
      nib = 4'h0;
      case (dig_idx[3:2])
         2'h0: nib = {3'h0, variant_o};
         2'h1: nib = gas_id_o[4*(3-dig_idx[1:0]) +: 4];
         2'h2: nib = inst_id_o[4*(3-dig_idx[1:0]) +: 4];
         2'h3: nib = status_o[4*(3-dig_idx[1:0]) +: 4];
         default: nib = 4'h0;
      endcase
      if (state_r == ST_TAIL)
         nib = {1'b0, bcc_fold[6:4]};
      else if (state_r == ST_BCC1)
         nib = bcc_r[3:0];
   end

   // Next state; each character waits for the sink to take it.
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (own_cmd) state_nxt = ST_LEAD;
         ST_LEAD: if (char_ready_i) state_nxt = ST_CONV;
         ST_CONV: state_nxt = ret_r;
         ST_BODY: if (char_ready_i) state_nxt = (idx_r == 4'hF) ? ST_TAIL : ST_CONV;
         ST_TAIL: if (char_ready_i) state_nxt = framed ? ST_CONV : ST_IDLE;
         ST_BCC1: if (char_ready_i) state_nxt = ST_CONV;
         ST_BCC2: if (char_ready_i) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Picks the next character; it loads only on a transition so a stalled character stays put.
   always @*
   begin
      char_load = 1'b0;
      char_new = hex_ch;
      if (state_r == ST_IDLE && own_cmd)
      begin
         char_load = 1'b1;
         char_new = framed_next ? `CH_STX : `CH_CR;
      end
      else if (state_r == ST_CONV)
         char_load = 1'b1;
      else if (state_r == ST_BODY && state_nxt == ST_TAIL)
      begin
         char_load = 1'b1;
         char_new = framed ? `CH_ETX : `CH_CR;
      end
   end

   // Sequencer registers.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_r <= ST_IDLE;
         mode_r <= `RMODE_CMD;
         enc_r <= `CENC_PLAIN;
         idx_r <= 4'h0;
         bcc_r <= 7'h00;
         ret_r <= ST_BODY;
         char_port_o <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && own_cmd)
         begin
            mode_r <= (resp_mode_i == `RMODE_TEXT || resp_mode_i == `RMODE_BCC) ? resp_mode_i : `RMODE_CMD;
            enc_r <= cmd_enc_i;
            char_port_o <= cmd_port_i;
            idx_r <= 4'h0;
            bcc_r <= 7'h00;
            ret_r <= ST_BODY;
         end
         if (char_ready_i && (state_r == ST_BODY || state_r == ST_TAIL) && state_nxt != ST_IDLE)
            bcc_r <= bcc_fold;
         if (state_r == ST_BODY && char_ready_i)
            idx_r <= idx_r + 4'h1;
         if (state_r == ST_TAIL && char_ready_i)
            ret_r <= ST_BCC1;
         else if (state_r == ST_BCC1 && char_ready_i)
            ret_r <= ST_BCC2;
      end
   end

   // Output character register with 7-bit even parity.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         char_valid_o <= 1'b0;
         char_o <= 7'h00;
         char_parity_o <= 1'b0;
      end
      else
      begin
         char_valid_o <= (state_nxt == ST_LEAD || state_nxt == ST_BODY || state_nxt == ST_TAIL
                          || state_nxt == ST_BCC1 || state_nxt == ST_BCC2);
         if (char_load)
         begin
            char_o <= char_new;
            char_parity_o <= ^char_new;
         end
      end
   end

   // Latency watchdog: flags a reply that outlasts the allowed time.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         lat_r <= 32'h00000000;
         timeout_o <= 1'b0;
      end
      else if (state_r == ST_IDLE)
      begin
         lat_r <= 32'h00000000;
         timeout_o <= 1'b0;
      end
      else
      begin
         if (lat_r != LATENCY_CYC[31:0])
            lat_r <= lat_r + 32'h00000001;
         timeout_o <= (lat_r == LATENCY_CYC[31:0]);
      end
   end

endmodule
`default_nettype wire

// *** core/reply_char_rom.v ***
`timescale 1ns/10ps
`default_nettype none
`include "status_responder_defines.vh"

module reply_char_rom
(
   input wire mclk_i,
   input wire rstn_i,
   input wire [3:0] nibble_i,
   output reg [6:0] ascii_o
);

   // ==========================================================================
   // Registered hex digit to ASCII conversion.
   // ==========================================================================

   // Digits 0-9 map to '0'..'9', 10-15 to 'A'..'F'.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ascii_o <= 7'h30;
      else if (nibble_i < 4'hA)
         ascii_o <= 7'h30 + {3'h0, nibble_i};
      else
         ascii_o <= 7'h37 + {3'h0, nibble_i};
   end

endmodule
`default_nettype wire

// *** core/status_responder_defines.vh ***
`ifndef STATUS_RESPONDER_DEFINES_VH
`define STATUS_RESPONDER_DEFINES_VH

// Protocol variants.
`define VARIANT_ORIGINAL 1'b0
`define VARIANT_FLEXIBLE 1'b1

// Response framing modes.
`define RMODE_CMD 2'h0
`define RMODE_BCC 2'h1
`define RMODE_TEXT 2'h2

// Command encoding seen by the parser.
`define CENC_PLAIN 1'b0
`define CENC_FRAMED 1'b1

// Framing characters, 7-bit.
`define CH_STX 7'h02
`define CH_ETX 7'h03
`define CH_CR 7'h0D
`define CH_LF 7'h0A

// Identifier defaults.
`define GAS_ID_DEFAULT 16'h0136 // Decimal 310.
`define INST_ID_DEFAULT 16'h0168 // Decimal 360.

// Flag indices into the flag vector.
`define FLAG_COUNT 12
`define FL_SAMPLE_FLOW 0
`define FL_BENCH_TEMP 1
`define FL_SOURCE 2
`define FL_BOX_TEMP 3
`define FL_WHEEL_TEMP 4
`define FL_SAMPLE_TEMP 5
`define FL_SAMPLE_PRES 6
`define FL_INVALID_CONC 7
`define FL_INST_OFF 8
`define FL_MANUAL_CAL 9
`define FL_ZERO_CAL 10
`define FL_SPAN_CAL 11

// Default status masks, one per flag.
`define DEF_SAMPLE_FLOW 16'h0001
`define DEF_BENCH_TEMP 16'h0002
`define DEF_SOURCE 16'h0004
`define DEF_BOX_TEMP 16'h0008
`define DEF_WHEEL_TEMP 16'h0010
`define DEF_SAMPLE_TEMP 16'h0020
`define DEF_SAMPLE_PRES 16'h0040
`define DEF_INVALID_CONC 16'h0080
`define DEF_INST_OFF 16'h0100
`define DEF_MANUAL_CAL 16'h0200
`define DEF_ZERO_CAL 16'h0400
`define DEF_SPAN_CAL 16'h0800

// Unit field in the status word.
`define UNIT_LSB 13
`define UNIT_MICROGRAMS 2'h0
`define UNIT_MILLIGRAMS 2'h1
`define UNIT_PPB 2'h2
`define UNIT_PPM 2'h3

// Reply latency ceiling.
`define REPLY_LATENCY_MS 200
`define CLK_MHZ 200

`endif

// *** verif/host_poller.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// Host end of the reply stream; it takes 7-bit characters, slowly if asked.
module host_poller
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic slow_i,
   input wire logic hold_i,
   input wire logic char_valid_i,
   input wire logic [6:0] char_i,
   input wire logic char_port_i,
   output logic ready_o
);
   logic [7:0] rx_q[$];
   logic [1:0] cnt_r;
   // Logs each taken character with its port; slow mode accepts one cycle in three.
   always @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_r <= 2'h0;
         ready_o <= 1'b0;
      end
      else
      begin
         if (char_valid_i && ready_o)
            rx_q.push_back({char_port_i, char_i});
         cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
         ready_o <= !hold_i && (!slow_i || cnt_r == 2'h1);
      end
   end
endmodule
`default_nettype wire

// *** verif/multidrop_status_responder_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker of the status responder.
module multidrop_status_responder_asserts
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic variant_i,
   input wire logic [1:0] port_en_i,
   input wire logic [15:0] inst_id_i,
   input wire logic inst_id_load_i,
   input wire logic [1:0] unit_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_port_i,
   input wire logic [15:0] cmd_id_i,
   input wire logic cmd_ready_o,
   input wire logic char_valid_o,
   input wire logic [6:0] char_o,
   input wire logic char_parity_o,
   input wire logic char_port_o,
   input wire logic char_ready_i,
   input wire logic [15:0] status_o,
   input wire logic [15:0] inst_id_o,
   input wire logic [15:0] gas_id_o,
   input wire logic busy_o,
   input wire logic variant_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // A command for this unit on an enabled port, seen while idle.
   wire logic take_w = cmd_valid_i && cmd_ready_o && port_en_i[cmd_port_i] && (cmd_id_i == inst_id_o);

   a_take_reply: assert property (take_w |-> ##[1:2] char_valid_o)
      else $error("addressed command got no reply");
   a_refuse_quiet: assert property (cmd_valid_i && cmd_ready_o && !take_w |=> cmd_ready_o && !char_valid_o)
      else $error("foreign command was taken");
   a_char_hold: assert property (char_valid_o && !char_ready_i |=> char_valid_o && $stable(char_o))
      else $error("reply character dropped before taken");
   a_parity_even: assert property (char_valid_o |-> char_parity_o == ^char_o)
      else $error("parity not even");
   a_gas_fixed: assert property (gas_id_o == 16'h0136)
      else $error("gas id wrong");
   a_unit_field: assert property ($stable(unit_i) [*4] |-> status_o[14:13] == unit_i)
      else $error("unit field wrong");
   a_variant_cap: assert property (!busy_o |=> variant_o == $past(variant_i))
      else $error("variant not captured while idle");
   a_id_load: assert property (inst_id_load_i |=> inst_id_o == $past(inst_id_i))
      else $error("instrument id not loaded");

   c_take: cover property (take_w);
   c_stall: cover property (char_valid_o && !char_ready_i);
   c_load_take: cover property (inst_id_load_i ##[1:8] take_w);
endmodule
`default_nettype wire

// *** verif/multidrop_status_responder_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "status_responder_defines.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t: %h not %h", $time, g, e); end end
// ==========
// Bench of the status responder with a host model on the reply stream.
module multidrop_status_responder_tb;
   typedef struct packed {logic [1:0] mode; logic enc; logic port; logic vnt; logic [1:0] unit; logic [11:0] fl;
      logic slow;} row_t;
   logic mclk_i = 1'b0, rstn_i = 1'b0, variant_i = 1'b0, inst_id_load_i = 1'b0, map_defaults_i = 1'b0;
   logic map_wr_i = 1'b0, cmd_valid_i = 1'b0, cmd_port_i = 1'b0, cmd_enc_i = 1'b0, slow = 1'b0, hold = 1'b0;
   logic [1:0] port_en_i = 2'h3, resp_mode_i = 2'h0, unit_i = 2'h0;
   logic [3:0] map_idx_i = 4'h0;
   logic [11:0] flags_i = 12'h000;
   logic [15:0] inst_id_i = 16'h0000, map_mask_i = 16'h0000, cmd_id_i = 16'h0000;
   wire logic cmd_ready_o, char_valid_o, char_parity_o, char_port_o, char_ready_i, variant_o, busy_o, timeout_o;
   wire logic [6:0] char_o;
   wire logic [15:0] status_o, inst_id_o, gas_id_o;
   logic [15:0] mask[12];
   int n_fail = 0, check_count = 0;
   // Mode, encoding, port, variant, unit, flags, slow host.
   row_t rows[5] = '{'{2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 12'h001, 1'b0}, '{2'h0, 1'b1, 1'b1, 1'b1, 2'h1, 12'h0F0, 1'b0},
      '{2'h1, 1'b0, 1'b0, 1'b0, 2'h2, 12'hF00, 1'b1}, '{2'h2, 1'b1, 1'b1, 1'b1, 2'h3, 12'hFFF, 1'b1},
      '{2'h3, 1'b1, 1'b0, 1'b0, 2'h1, 12'hAAA, 1'b0}};

   multidrop_status_responder #(.LATENCY_CYC(400)) uut (.mclk_i, .rstn_i, .variant_i, .port_en_i, .resp_mode_i,
      .inst_id_i, .inst_id_load_i, .flags_i, .unit_i, .map_defaults_i, .map_wr_i, .map_idx_i, .map_mask_i,
      .cmd_valid_i, .cmd_port_i, .cmd_id_i, .cmd_enc_i, .cmd_ready_o, .char_valid_o, .char_o, .char_parity_o,
      .char_port_o, .char_ready_i, .status_o, .inst_id_o, .gas_id_o, .variant_o, .busy_o, .timeout_o);
   host_poller host (.mclk_i, .rstn_i, .slow_i(slow), .hold_i(hold), .char_valid_i(char_valid_o), .char_i(char_o),
      .char_port_i(char_port_o), .ready_o(char_ready_i));

   // ==========
   // Helpers.
   function automatic logic [6:0] hx(input logic [3:0] d);
      return (d < 4'hA) ? 7'h30 + d : 7'h37 + d;
   endfunction
   function automatic logic [15:0] st_exp();
      logic [15:0] s;
      s = {1'b0, unit_i, 13'h0000};
      foreach (mask[i])
         if (flags_i[i])
            s |= mask[i];
      return s;
   endfunction
   task automatic set_defaults();
      foreach (mask[i])
         mask[i] = 16'h0001 << i;
   endtask
   task automatic map(input logic [3:0] idx, input logic [15:0] m);
      map_wr_i <= 1'b1;
      map_idx_i <= idx;
      map_mask_i <= m;
      @(posedge mclk_i);
      map_wr_i <= 1'b0;
      @(posedge mclk_i);
      mask[idx] = m;
   endtask
   // Sends one command and compares the whole reply, or its absence.
   task automatic poll(input logic port, input logic [15:0] id, input logic enc, input logic answered);
      logic [6:0] e[$];
      logic [6:0] bcc;
      logic [15:0] w[4];
      int k;
      logic to_seen;
      w = '{{4{3'h0, variant_i}}, `GAS_ID_DEFAULT, id, st_exp()};
      for (k = 0; k < 16; k++)
         e.push_back(hx(w[k / 4][15 - 4 * (k % 4) -: 4]));
      if (resp_mode_i == 2'h1 || (resp_mode_i != 2'h2 && enc))
      begin
         bcc = `CH_ETX;
         foreach (e[j])
            bcc ^= e[j];
         e.push_front(`CH_STX);
         e.push_back(`CH_ETX);
         e.push_back(hx({1'b0, bcc[6:4]}));
         e.push_back(hx(bcc[3:0]));
      end
      else
      begin
         e.push_front(`CH_CR);
         e.push_back(`CH_CR);
      end
      if (!answered)
         e.delete();
      host.rx_q.delete();
      cmd_valid_i <= 1'b1;
      cmd_port_i <= port;
      cmd_id_i <= id;
      cmd_enc_i <= enc;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      to_seen = 1'b0;
      for (k = 0; busy_o !== 1'b0 && k < 800; k++)
      begin
         @(posedge mclk_i);
         to_seen |= timeout_o;
      end
      repeat (3) @(posedge mclk_i);
      `CHK(to_seen, 1'b0)
      `CHK(busy_o, 1'b0)
      `CHK(host.rx_q.size(), e.size())
      foreach (e[j])
         if (j < host.rx_q.size())
            `CHK(host.rx_q[j], {port, e[j]})
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========
   // Clock, watchdog and test sequence.
   initial
   begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   initial
   begin
      #100000;
      n_fail++;
      end_sim();
   end
   initial
   begin
      set_defaults();
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(posedge mclk_i);
      `CHK(inst_id_o, `INST_ID_DEFAULT)
      `CHK(gas_id_o, `GAS_ID_DEFAULT)
      `CHK(status_o, 16'h0000)
      `CHK(cmd_ready_o, 1'b1)
      `CHK(char_valid_o, 1'b0)
      $display("reset test done");
      foreach (rows[r])
      begin
         resp_mode_i <= rows[r].mode;
         variant_i <= rows[r].vnt;
         unit_i <= rows[r].unit;
         flags_i <= rows[r].fl;
         slow <= rows[r].slow;
         repeat (6) @(posedge mclk_i);
         `CHK(status_o, st_exp())
         `CHK(variant_o, rows[r].vnt)
         poll(rows[r].port, `INST_ID_DEFAULT, rows[r].enc, 1'b1);
         $display("row %0d done", r);
      end
      slow <= 1'b0;
      resp_mode_i <= 2'h1;
      poll(1'b0, 16'h0169, 1'b0, 1'b0);
      port_en_i <= 2'h1;
      poll(1'b1, `INST_ID_DEFAULT, 1'b0, 1'b0);
      poll(1'b0, `INST_ID_DEFAULT, 1'b1, 1'b1);
      port_en_i <= 2'h3;
      $display("refusal test done");
      unit_i <= 2'h0;
      flags_i <= 12'h00E;
      map(4'h1, 16'h0001);
      map(4'h2, 16'h8000);
      map(4'h3, 16'h0000);
      repeat (4) @(posedge mclk_i);
      `CHK(status_o, 16'h8001)
      poll(1'b1, `INST_ID_DEFAULT, 1'b0, 1'b1);
      map_defaults_i <= 1'b1;
      @(posedge mclk_i);
      map_defaults_i <= 1'b0;
      set_defaults();
      repeat (5) @(posedge mclk_i);
      `CHK(status_o, 16'h000E)
      $display("map test done");
      inst_id_i <= 16'h0A5C;
      inst_id_load_i <= 1'b1;
      @(posedge mclk_i);
      inst_id_load_i <= 1'b0;
      @(posedge mclk_i);
      `CHK(inst_id_o, 16'h0A5C)
      poll(1'b0, `INST_ID_DEFAULT, 1'b0, 1'b0);
      poll(1'b1, 16'h0A5C, 1'b1, 1'b1);
      $display("id test done");
      // Host holds off a whole reply: the latency flag must rise and the character must wait.
      hold <= 1'b1;
      cmd_valid_i <= 1'b1;
      cmd_port_i <= 1'b0;
      cmd_id_i <= 16'h0A5C;
      @(posedge mclk_i);
      cmd_valid_i <= 1'b0;
      repeat (405) @(posedge mclk_i);
      `CHK(timeout_o, 1'b1)
      `CHK(char_valid_o, 1'b1)
      hold <= 1'b0;
      repeat (120) @(posedge mclk_i);
      `CHK(busy_o, 1'b0)
      `CHK(timeout_o, 1'b0)
      $display("stall test done");
      end_sim();
   end
endmodule

bind multidrop_status_responder multidrop_status_responder_asserts chk (.mclk_i, .rstn_i, .variant_i, .port_en_i,
   .inst_id_i, .inst_id_load_i, .unit_i, .cmd_valid_i, .cmd_port_i, .cmd_id_i, .cmd_ready_o, .char_valid_o, .char_o,
   .char_parity_o, .char_port_o, .char_ready_i, .status_o, .inst_id_o, .gas_id_o, .busy_o, .variant_o);
`default_nettype wire
